// ===== hhlc_pkg.sv
// Constants, register map and shared types of the holdover history and loop control block.
package hhlc_pkg;

  // Clock rate and the one millisecond base of the averaging interval.
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TICK_TIME_MS    = 1;
  localparam int unsigned MS_TICK_CYCLES  = (CLK_HZ / MS_PER_S) * TICK_TIME_MS;

  // Data widths.
  localparam int unsigned FSW_W   = 48;
  localparam int unsigned TMR_W   = 24;
  localparam int unsigned ACC_W   = FSW_W + TMR_W;
  localparam int unsigned NREF    = 4;
  localparam int unsigned REF_W   = 2;
  localparam int unsigned ADDR_W  = 14;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_FREE_RUN_LO  = 12'h300;
  localparam logic [11:0] IDX_FREE_RUN_HI  = 12'h301;
  localparam logic [11:0] IDX_AVG_TIMER    = 12'h318;
  localparam logic [11:0] IDX_HIST_MODE    = 12'h31b;
  localparam logic [11:0] IDX_LOOP_MODE    = 12'ha01;
  localparam logic [11:0] IDX_HIST_CLEAR   = 12'ha03;
  localparam logic [11:0] IDX_LOOP_STATUS  = 12'hd0a;
  localparam logic [11:0] IDX_HISTORY_LO   = 12'hd14;
  localparam logic [11:0] IDX_HISTORY_HI   = 12'hd15;

  // Field positions.
  localparam int unsigned HC_CLEAR_BIT     = 2;
  localparam int unsigned ST_ACT_REF_LSB   = 4;
  localparam int unsigned ST_HIST_VLD_BIT  = 8;
  localparam int unsigned ST_HIST_UPD_BIT  = 9;

  // Reset values.
  localparam logic [47:0] FREE_RUN_RST     = 48'h000000000000;
  localparam logic [23:0] AVG_TIMER_RST    = 24'h0003e8;
  localparam logic [7:0]  HIST_MODE_RST    = 8'h00;
  localparam logic [7:0]  LOOP_MODE_RST    = 8'h00;

  // History mode control, bits [4:0].
  typedef struct packed {
    logic       fallback;
    logic       persist;
    logic [2:0] k;
  } hhlc_hist_mode_t;

  // Loop mode control, bits [6:0].
  typedef struct packed {
    logic             user_hold;
    logic             user_free;
    logic             force_ref;
    logic [1:0]       spare;
    logic [REF_W-1:0] ref_sel;
  } hhlc_loop_mode_t;

  typedef enum logic [1:0] {FREE_RUN, CLOSED_LOOP, SWITCHOVER, HOLDOVER} hhlc_state_t;

endpackage : hhlc_pkg

// ===== hhlc_top.sv
// Holdover history averaging and loop control state machine with its APB register file.
//
// Overview of operation
// R1: Every change to a different reference restarts history accumulation.
// R2: Without persistence a reference change discards the stored history.
// R3: Writing the clear bit of the history clear register erases history.
// R4: The history clear pin erases history while asserted.
// R5: With persistence set, history survives a reference change.
// R6: With no history and K of zero, nothing is stored until the interval timer expires.
// R7: Field K sets intermediate averages in the first interval after clearing.
// R8: K of zero gives no intermediate averages.
// R9: Intermediate averages fall at interval over 2^K, doubling up to the interval.
// R10: After the first interval, averages fall one full interval apart.
// R11: Loop mode register forces holdover, free-run or a chosen reference.
// R12: State machine sequences switchover and holdover, loading the active profile.
// R13: Switchover passes one cycle through holdover, then closes on the new reference.
// R14: Lock outputs keep their values during switchover.
// R15: Holdover is open loop with a constant tuning word.
// R16: With history, holdover uses the latest averaged history value.
// R17: Without history and fallback clear, holdover uses the free-run word.
// R18: Without history and fallback set, holdover uses the last applied word.
// R19: A valid reference in automatic holdover returns the loop to closed loop.
// R20: User holdover keeps holdover despite valid references until cleared.
// R21: Tuning words are 48 bits wide throughout.
// R22: Interval is a 24-bit millisecond count, one at least; the code accepts a write of zero without a check.
// R23: Each interval average goes to the history register, independent of earlier ones.
// R24: Each average emits a strobe and sets the history updated flag.
// R25: Free-run outputs the free-run word; closed loop the loop filter word.
//
// The APB slave port was decided locally.
module hhlc_top #(
  parameter int unsigned TICK_CYCLES = hhlc_pkg::MS_TICK_CYCLES
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [hhlc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic [hhlc_pkg::FSW_W-1:0]  loop_fsw_i,
  input  wire logic [hhlc_pkg::NREF-1:0]   ref_valid_i,
  input  wire logic                        phase_lock_i,
  input  wire logic                        freq_lock_i,
  input  wire logic                        hist_clear_pin_i,
  output logic      [hhlc_pkg::FSW_W-1:0]  frequency_step_word_o,
  output logic      [1:0]                  loop_state_o,
  output logic      [hhlc_pkg::REF_W-1:0]  active_ref_o,
  output logic                             open_loop_o,
  output logic                             profile_load_o,
  output logic                             phase_lock_o,
  output logic                             freq_lock_o,
  output logic                             hist_strobe_o
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // Lowest numbered valid reference wins in automatic selection.
  function automatic logic [hhlc_pkg::REF_W-1:0] first_valid(input logic [hhlc_pkg::NREF-1:0] v);
    logic [hhlc_pkg::REF_W-1:0] idx;
    idx = '0;
    for (int i = hhlc_pkg::NREF - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = hhlc_pkg::REF_W'(i);
      end
    end
    return idx;
  endfunction : first_valid

  logic [47:0]                free_run_q;
  logic [23:0]                avg_timer_q;
  logic [7:0]                 hist_mode_q;
  logic [7:0]                 loop_mode_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic [31:0]                prdata_q;
  logic [TW-1:0]              tick_cnt_q;
  logic                       ms_tick_q;
  logic [hhlc_pkg::ACC_W-1:0] acc_q;
  logic [23:0]                smp_cnt_q;
  logic [23:0]                ms_cnt_q;
  logic                       first_q;
  logic [2:0]                 k_left_q;
  logic                       div_busy_q;
  logic [6:0]                 div_step_q;
  logic [hhlc_pkg::ACC_W-1:0] div_num_q;
  logic [23:0]                div_den_q;
  logic [23:0]                div_rem_q;
  logic [47:0]                history_q;
  logic                       hist_valid_q;
  logic                       hist_upd_q;
  logic                       hist_strobe_q;
  hhlc_pkg::hhlc_state_t      state_q;
  hhlc_pkg::hhlc_state_t      state_d;
  logic [hhlc_pkg::REF_W-1:0] active_ref_q;
  logic [47:0]                hold_word_q;
  logic [47:0]                fsw_q;
  logic                       profile_load_q;
  logic                       open_loop_q;
  logic                       phase_lock_q;
  logic                       freq_lock_q;

  // Register decode.
  wire logic [11:0]                idx_w    = paddr_i[13:2];
  wire logic                       access_w = psel_i && penable_i;
  wire logic                       wr_en_w  = access_w && pready_q && pwrite_i;
  wire hhlc_pkg::hhlc_hist_mode_t  hm_w     = hist_mode_q[4:0];
  wire hhlc_pkg::hhlc_loop_mode_t  lm_w     = loop_mode_q[6:0];
  wire logic                       hit_reg_w;
  wire logic [31:0]                rd_word_w;

  assign hit_reg_w = (idx_w == hhlc_pkg::IDX_FREE_RUN_LO) || (idx_w == hhlc_pkg::IDX_FREE_RUN_HI) ||
                     (idx_w == hhlc_pkg::IDX_AVG_TIMER)   || (idx_w == hhlc_pkg::IDX_HIST_MODE)   ||
                     (idx_w == hhlc_pkg::IDX_LOOP_MODE)   || (idx_w == hhlc_pkg::IDX_HIST_CLEAR)  ||
                     (idx_w == hhlc_pkg::IDX_LOOP_STATUS) || (idx_w == hhlc_pkg::IDX_HISTORY_LO)  ||
                     (idx_w == hhlc_pkg::IDX_HISTORY_HI);

  // Read mux; the clear register is an action register and reads as zero.
  assign rd_word_w =
    (idx_w == hhlc_pkg::IDX_FREE_RUN_LO) ? free_run_q[31:0] :
    (idx_w == hhlc_pkg::IDX_FREE_RUN_HI) ? {16'h0000, free_run_q[47:32]} :
    (idx_w == hhlc_pkg::IDX_AVG_TIMER)   ? {8'h00, avg_timer_q} :
    (idx_w == hhlc_pkg::IDX_HIST_MODE)   ? {24'h000000, hist_mode_q} :
    (idx_w == hhlc_pkg::IDX_LOOP_MODE)   ? {24'h000000, loop_mode_q} :
    (idx_w == hhlc_pkg::IDX_LOOP_STATUS) ? {22'h0, hist_upd_q, hist_valid_q, 2'b00, active_ref_q, 2'b00, state_q} :
    (idx_w == hhlc_pkg::IDX_HISTORY_LO)  ? history_q[31:0] :
    (idx_w == hhlc_pkg::IDX_HISTORY_HI)  ? {16'h0000, history_q[47:32]} : 32'h00000000;

  // One wait state keeps read data and ready straight from flip-flops.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= access_w && !pready_q;
      pslverr_q <= access_w && !pready_q && !hit_reg_w;
      prdata_q  <= (access_w && !pready_q && !pwrite_i && hit_reg_w) ? rd_word_w : 32'h00000000;
    end
  end

  // Software registers; the interval is a 24-bit millisecond count.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      free_run_q  <= hhlc_pkg::FREE_RUN_RST;
      avg_timer_q <= hhlc_pkg::AVG_TIMER_RST;
      hist_mode_q <= hhlc_pkg::HIST_MODE_RST;
      loop_mode_q <= hhlc_pkg::LOOP_MODE_RST;
    end
    else if (wr_en_w)
    begin
      if (idx_w == hhlc_pkg::IDX_FREE_RUN_LO) free_run_q[31:0]  <= pwdata_i;
      if (idx_w == hhlc_pkg::IDX_FREE_RUN_HI) free_run_q[47:32] <= pwdata_i[15:0];
      if (idx_w == hhlc_pkg::IDX_AVG_TIMER)   avg_timer_q       <= pwdata_i[23:0]; // R22
      if (idx_w == hhlc_pkg::IDX_HIST_MODE)   hist_mode_q       <= pwdata_i[7:0];
      if (idx_w == hhlc_pkg::IDX_LOOP_MODE)   loop_mode_q       <= pwdata_i[7:0]; // R11
    end
  end

  // Clear from software or from the multipurpose pin, and the W1C of the updated flag.
  wire logic clr_w = (wr_en_w && (idx_w == hhlc_pkg::IDX_HIST_CLEAR) && pwdata_i[hhlc_pkg::HC_CLEAR_BIT])
                     || hist_clear_pin_i; // R3 R4
  wire logic upd_w1c_w = wr_en_w && (idx_w == hhlc_pkg::IDX_LOOP_STATUS) && pwdata_i[hhlc_pkg::ST_HIST_UPD_BIT];

  // Reference choice: forced by software or first valid input.
  wire logic [hhlc_pkg::REF_W-1:0] sel_ref_w = lm_w.force_ref ? lm_w.ref_sel : first_valid(ref_valid_i); // R11
  wire logic sel_valid_w = ref_valid_i[sel_ref_w];
  wire logic close_w     = (state_d == hhlc_pkg::CLOSED_LOOP) && (state_q != hhlc_pkg::CLOSED_LOOP);
  wire logic ref_chg_w   = close_w && (sel_ref_w != active_ref_q); // R1
  wire logic restart_w   = clr_w || ref_chg_w; // R1
  wire logic wipe_w      = clr_w || (ref_chg_w && !hm_w.persist); // R2 R5

  // Loop state machine; user free-run outranks user holdover.
  always_comb
  begin
    state_d = state_q;
    if (lm_w.user_free)
    begin
      state_d = hhlc_pkg::FREE_RUN; // R11
    end
    else if (lm_w.user_hold)
    begin
      state_d = hhlc_pkg::HOLDOVER; // R20
    end
    else if (sel_valid_w)
    begin
      unique case (state_q)
        hhlc_pkg::CLOSED_LOOP: state_d = (sel_ref_w != active_ref_q) ? hhlc_pkg::SWITCHOVER
                                                                     : hhlc_pkg::CLOSED_LOOP; // R12
        hhlc_pkg::SWITCHOVER:  state_d = hhlc_pkg::CLOSED_LOOP; // R13
        hhlc_pkg::HOLDOVER:    state_d = hhlc_pkg::CLOSED_LOOP; // R19
        hhlc_pkg::FREE_RUN:    state_d = hhlc_pkg::CLOSED_LOOP;
      endcase
    end
    else if ((state_q == hhlc_pkg::CLOSED_LOOP) || (state_q == hhlc_pkg::SWITCHOVER))
    begin
      state_d = hhlc_pkg::HOLDOVER; // R12
    end
  end

  // Holdover word is frozen on entry so it cannot drift while open loop.
  wire logic in_hold_d_w = (state_d == hhlc_pkg::HOLDOVER) || (state_d == hhlc_pkg::SWITCHOVER);
  wire logic in_hold_q_w = (state_q == hhlc_pkg::HOLDOVER) || (state_q == hhlc_pkg::SWITCHOVER);
  wire logic enter_hold_w = in_hold_d_w && !in_hold_q_w;
  wire logic [47:0] hold_src_w = hist_valid_q ? history_q : // R16
                                 hm_w.fallback ? fsw_q : free_run_q; // R17 R18

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_q        <= hhlc_pkg::FREE_RUN;
      active_ref_q   <= '0;
      hold_word_q    <= 48'h000000000000;
      fsw_q          <= 48'h000000000000;
      profile_load_q <= 1'b0;
      open_loop_q    <= 1'b1;
      phase_lock_q   <= 1'b0;
      freq_lock_q    <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      active_ref_q   <= close_w ? sel_ref_w : active_ref_q; // R12
      hold_word_q    <= enter_hold_w ? hold_src_w : hold_word_q; // R15
      profile_load_q <= close_w; // R12 R19
      open_loop_q    <= state_d != hhlc_pkg::CLOSED_LOOP; // R15
      // Tuning word source per mode.
      fsw_q <= (state_d == hhlc_pkg::CLOSED_LOOP) ? loop_fsw_i :
               (state_d == hhlc_pkg::FREE_RUN)    ? free_run_q :
               enter_hold_w ? hold_src_w : hold_word_q; // R25 R15 R21
      // Lock indication held across a switchover, unlocked when open loop.
      phase_lock_q <= (state_d == hhlc_pkg::CLOSED_LOOP) ? phase_lock_i :
                      (state_d == hhlc_pkg::SWITCHOVER)  ? phase_lock_q : 1'b0; // R14
      freq_lock_q  <= (state_d == hhlc_pkg::CLOSED_LOOP) ? freq_lock_i :
                      (state_d == hhlc_pkg::SWITCHOVER)  ? freq_lock_q : 1'b0; // R14
    end
  end

  // Millisecond tick divider.
  wire logic tick_wrap_w = tick_cnt_q == TW'(TICK_CYCLES - 1);

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_wrap_w ? '0 : tick_cnt_q + 1'b1;
      ms_tick_q  <= tick_wrap_w;
    end
  end

  // One loop filter sample per millisecond of closed loop feeds the average.
  wire logic                       smp_w      = ms_tick_q && (state_q == hhlc_pkg::CLOSED_LOOP);
  wire logic [23:0]                ms_next_w  = ms_cnt_q + 24'h000001;
  wire logic [23:0]                cnt_next_w = smp_cnt_q + 24'h000001;
  wire logic [hhlc_pkg::ACC_W-1:0] acc_next_w = acc_q + {24'h000000, loop_fsw_i};
  wire logic [23:0]                chk_w      = first_q ? (avg_timer_q >> k_left_q) : avg_timer_q; // R9 R10
  wire logic                       hit_w      = smp_w && (ms_next_w >= chk_w); // R6
  wire logic                       inter_w    = hit_w && first_q && (k_left_q != 3'h0); // R7 R8
  wire logic                       launch_w   = hit_w && !restart_w;

  // The sum and the millisecond count restart at the full interval and on a restart, not at an intermediate average.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      acc_q     <= '0;
      smp_cnt_q <= 24'h000000;
      ms_cnt_q  <= 24'h000000;
      first_q   <= 1'b1;
      k_left_q  <= 3'h0;
    end
    else if (restart_w)
    begin
      acc_q     <= '0; // R1
      smp_cnt_q <= 24'h000000;
      ms_cnt_q  <= 24'h000000;
      first_q   <= wipe_w || (first_q && !hist_valid_q);
      k_left_q  <= wipe_w ? hm_w.k : k_left_q; // R7
    end
    else if (smp_w)
    begin
      if (hit_w && !inter_w)
      begin
        acc_q     <= '0; // R23
        smp_cnt_q <= 24'h000000;
        ms_cnt_q  <= 24'h000000;
        first_q   <= 1'b0; // R10
      end
      else
      begin
        acc_q     <= acc_next_w;
        smp_cnt_q <= cnt_next_w;
        ms_cnt_q  <= ms_next_w;
        k_left_q  <= inter_w ? k_left_q - 3'h1 : k_left_q; // R9
      end
    end
  end

  // Restoring divider: 72 cycles per average, far shorter than one millisecond.
  wire logic [24:0] rem_sh_w    = {div_rem_q, div_num_q[hhlc_pkg::ACC_W-1]};
  wire logic        q_bit_w     = rem_sh_w >= {1'b0, div_den_q};
  wire logic [24:0] rem_sub_w   = rem_sh_w - {1'b0, div_den_q};
  wire logic [23:0] rem_step_w  = q_bit_w ? rem_sub_w[23:0] : rem_sh_w[23:0];
  wire logic        div_done_w  = div_busy_q && (div_step_q == 7'(hhlc_pkg::ACC_W - 1)) && !wipe_w;
  wire logic [47:0] quotient_w  = {div_num_q[46:0], q_bit_w};

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      div_busy_q <= 1'b0;
      div_step_q <= 7'h00;
      div_num_q  <= '0;
      div_den_q  <= 24'h000000;
      div_rem_q  <= 24'h000000;
    end
    else if (wipe_w)
    begin
      div_busy_q <= 1'b0; // R2 R3
    end
    else if (launch_w)
    begin
      div_busy_q <= 1'b1;
      div_step_q <= 7'h00;
      div_num_q  <= acc_next_w;
      div_den_q  <= cnt_next_w;
      div_rem_q  <= 24'h000000;
    end
    else if (div_busy_q)
    begin
      div_busy_q <= !div_done_w;
      div_step_q <= div_step_q + 7'h01;
      div_num_q  <= {div_num_q[hhlc_pkg::ACC_W-2:0], q_bit_w};
      div_rem_q  <= rem_step_w;
    end
  end

  // History store, strobe and sticky flag; a new result outranks the W1C.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      history_q     <= 48'h000000000000;
      hist_valid_q  <= 1'b0;
      hist_upd_q    <= 1'b0;
      hist_strobe_q <= 1'b0;
    end
    else
    begin
      hist_strobe_q <= div_done_w; // R24
      hist_upd_q    <= div_done_w || (hist_upd_q && !upd_w1c_w); // R24
      if (wipe_w)
      begin
        hist_valid_q <= 1'b0; // R2 R3 R4
      end
      else if (div_done_w)
      begin
        history_q    <= quotient_w; // R23
        hist_valid_q <= 1'b1;
      end
    end
  end

  assign prdata_o              = prdata_q;
  assign pready_o              = pready_q;
  assign pslverr_o             = pslverr_q;
  assign frequency_step_word_o = fsw_q;
  assign loop_state_o          = state_q;
  assign active_ref_o          = active_ref_q;
  assign open_loop_o           = open_loop_q;
  assign profile_load_o        = profile_load_q;
  assign phase_lock_o          = phase_lock_q;
  assign freq_lock_o           = freq_lock_q;
  assign hist_strobe_o         = hist_strobe_q;

  // Checks on the history and loop behaviour.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_restart_zeroes;
    restart_w |=> (ms_cnt_q == 24'h000000) && (smp_cnt_q == 24'h000000);
  endproperty
  a_restart_zeroes: assert property (p_restart_zeroes) else $error("accumulation not restarted"); // R1

  property p_nonpersist_drop;
    ref_chg_w && !hm_w.persist |=> !hist_valid_q;
  endproperty
  a_nonpersist_drop: assert property (p_nonpersist_drop) else $error("history kept without persistence"); // R2

  property p_clear_erases;
    clr_w |=> !hist_valid_q;
  endproperty
  a_clear_erases: assert property (p_clear_erases) else $error("history survived a clear"); // R3

  property p_pin_clear;
    hist_clear_pin_i |=> !hist_valid_q && !div_busy_q;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin clear ignored"); // R4

  property p_persist_keeps;
    ref_chg_w && hm_w.persist && !clr_w && hist_valid_q |=> hist_valid_q;
  endproperty
  a_persist_keeps: assert property (p_persist_keeps) else $error("persistent history lost"); // R5

  property p_switch_closes;
    (state_q == hhlc_pkg::SWITCHOVER) && !lm_w.user_free && !lm_w.user_hold && sel_valid_w
      |=> (state_q == hhlc_pkg::CLOSED_LOOP) && profile_load_o;
  endproperty
  a_switch_closes: assert property (p_switch_closes) else $error("switchover did not close"); // R13

  property p_lock_held;
    (state_q == hhlc_pkg::SWITCHOVER) |-> $stable(phase_lock_o) && $stable(freq_lock_o);
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("lock changed in switchover"); // R14

  property p_hold_constant;
    (state_q == hhlc_pkg::HOLDOVER) [*2] |-> $stable(frequency_step_word_o) && open_loop_o;
  endproperty
  a_hold_constant: assert property (p_hold_constant) else $error("holdover word moved"); // R15

  property p_hold_history;
    enter_hold_w && hist_valid_q |=> hold_word_q == $past(history_q);
  endproperty
  a_hold_history: assert property (p_hold_history) else $error("holdover not from history"); // R16

  property p_hold_free;
    enter_hold_w && !hist_valid_q && !hm_w.fallback |=> hold_word_q == $past(free_run_q);
  endproperty
  a_hold_free: assert property (p_hold_free) else $error("holdover not from free-run word"); // R17

  property p_hold_last;
    enter_hold_w && !hist_valid_q && hm_w.fallback |=> hold_word_q == $past(frequency_step_word_o);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("holdover not from last word"); // R18

  property p_user_hold;
    lm_w.user_hold && !lm_w.user_free |=> state_q == hhlc_pkg::HOLDOVER;
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("left user holdover"); // R20

  property p_strobe_flag;
    div_done_w |=> hist_strobe_o && hist_upd_q && hist_valid_q;
  endproperty
  a_strobe_flag: assert property (p_strobe_flag) else $error("average without strobe or flag"); // R24

  property p_free_word;
    (state_q == hhlc_pkg::FREE_RUN) |-> frequency_step_word_o == $past(free_run_q);
  endproperty
  a_free_word: assert property (p_free_word) else $error("free-run word not applied"); // R25

endmodule : hhlc_top

// ===== hhlc_top_tb.sv
// Self-checking testbench of the holdover history and loop control block.
module hhlc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // A hundred clocks stand in for one millisecond; the divider needs 72, so the tick must be longer.
  localparam int unsigned TCK = 100;
  localparam logic [47:0] W1 = 48'h0a1b2c3d4e5f;
  localparam logic [47:0] W2 = 48'h00ffee001122;
  localparam logic [47:0] FR = 48'h12349abcdef0;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [13:0] paddr     = 14'h0000;
  logic [31:0] pwdata    = 32'h0;
  logic [47:0] lfsw      = W1;
  logic [3:0]  rv        = 4'h0;
  logic        hcp       = 1'b0;
  logic        lk        = 1'b1;
  logic [31:0] prdata, q;
  logic [47:0] fsw;
  logic [1:0]  st, aref;
  logic        pready, pslverr, se, ol, pl, plo, flo, hs;
  int          err_count = 0;
  int          compares  = 0;
  int          cyc       = 0;
  int          n;

  hhlc_top #(.TICK_CYCLES(TCK)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .loop_fsw_i(lfsw), .ref_valid_i(rv),
    .phase_lock_i(lk), .freq_lock_i(lk), .hist_clear_pin_i(hcp),
    .frequency_step_word_o(fsw), .loop_state_o(st), .active_ref_o(aref),
    .open_loop_o(ol), .profile_load_o(pl), .phase_lock_o(plo), .freq_lock_o(flo),
    .hist_strobe_o(hs));

  // Clock, and a cycle ceiling so that a hung handshake still ends the run.
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    q  = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits k edges and lets registered outputs settle.
  task automatic ed(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : ed

  // Changes the reference valid levels at a rising edge.
  task automatic set_rv(input logic [3:0] v);
    @(posedge clk_sys_i);
    rv <= v;
  endtask : set_rv

  task automatic end_of_test();
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Waits for the next stored average; with K ignored it would come far too late.
  task automatic wait_hs();
    n = 0;
    do
    begin
      ed(1);
      n++;
    end
    while (hs !== 1'b1 && n < 400);
    chk(n >= 72 && n <= 2 * TCK + 80, 48'h1);
  endtask : wait_hs

  // Reset values, an unmapped read and the free-run word.
  task automatic sc_regs();
    ed(1);
    chk(st, 48'h0);
    chk(ol, 48'h1);
    apb(1'b0, hhlc_pkg::IDX_HIST_MODE, 32'h0);
    chk(q, hhlc_pkg::HIST_MODE_RST);
    apb(1'b0, 12'hfff, 32'h0);
    chk({se, q}, {1'b1, 32'h0});
    apb(1'b1, hhlc_pkg::IDX_FREE_RUN_LO, 32'h9abcdef0);
    apb(1'b1, hhlc_pkg::IDX_FREE_RUN_HI, 32'h00001234);
    ed(1);
    chk(fsw, FR);
  endtask : sc_regs

  // Closed loop on reference zero, then holdover with no history.
  task automatic sc_loop();
    set_rv(4'h1);
    ed(1);
    chk({st, pl}, {2'h1, 1'b1});
    ed(1);
    chk(fsw, W1);
    set_rv(4'h0);
    ed(2);
    chk({st, plo, ol}, {2'h3, 1'b0, 1'b1});
    chk(fsw, FR);
  endtask : sc_loop

  // Interval of four with K of two and persistence, so the first average lands after one tick.
  task automatic sc_history();
    apb(1'b1, hhlc_pkg::IDX_AVG_TIMER, 32'h4);
    apb(1'b1, hhlc_pkg::IDX_HIST_MODE, 32'h0a);
    apb(1'b1, hhlc_pkg::IDX_HIST_CLEAR, 32'h4);
    set_rv(4'h1);
    wait_hs();
    apb(1'b0, hhlc_pkg::IDX_HISTORY_LO, 32'h0);
    chk(q, W1[31:0]);
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk(q[9:8], 48'h3);
    apb(1'b1, hhlc_pkg::IDX_LOOP_STATUS, 32'h200);
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk(q[9:8], 48'h1);
  endtask : sc_history

  // Switchover with the lock inputs dropped, then holdover from history.
  task automatic sc_switch();
    @(posedge clk_sys_i);
    rv <= 4'h2;
    lk <= 1'b0;
    ed(1);
    chk(st, 48'h2);
    chk({plo, flo}, 48'h3);
    ed(1);
    chk({st, aref, pl}, {2'h1, 2'h1, 1'b1});
    chk(plo, 48'h0);
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk(q[8], 48'h1);
    @(posedge clk_sys_i);
    lfsw <= W2;
    rv   <= 4'h0;
    lk   <= 1'b1;
    ed(2);
    chk({st, fsw}, {2'h3, W1});
  endtask : sc_switch

  // User holdover, recovery, user free-run and the single-sample fallback.
  task automatic sc_user();
    apb(1'b1, hhlc_pkg::IDX_LOOP_MODE, 32'h40);
    set_rv(4'h1);
    ed(3);
    chk(st, 48'h3);
    apb(1'b1, hhlc_pkg::IDX_LOOP_MODE, 32'h0);
    ed(2);
    chk(st, 48'h1);
    apb(1'b1, hhlc_pkg::IDX_LOOP_MODE, 32'h60);
    ed(1);
    chk({st, fsw}, {2'h0, FR});
    apb(1'b1, hhlc_pkg::IDX_LOOP_MODE, 32'h0);
    apb(1'b1, hhlc_pkg::IDX_HIST_MODE, 32'h10);
    apb(1'b1, hhlc_pkg::IDX_HIST_CLEAR, 32'h4);
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk(q[8], 48'h0);
    set_rv(4'h0);
    ed(2);
    chk(fsw, W2);
  endtask : sc_user

  // Pin clear of a fresh history, then a forced change to reference one without persistence.
  task automatic sc_clear();
    apb(1'b1, hhlc_pkg::IDX_HIST_MODE, 32'h02);
    apb(1'b1, hhlc_pkg::IDX_HIST_CLEAR, 32'h4);
    set_rv(4'h1);
    wait_hs();
    @(posedge clk_sys_i);
    hcp <= 1'b1;
    @(posedge clk_sys_i);
    hcp <= 1'b0;
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk(q[8], 48'h0);
    wait_hs();
    set_rv(4'h3);
    apb(1'b1, hhlc_pkg::IDX_LOOP_MODE, 32'h11);
    ed(2);
    apb(1'b0, hhlc_pkg::IDX_LOOP_STATUS, 32'h0);
    chk({q[8], q[5:4]}, {1'b0, 2'h1});
  endtask : sc_clear

  // Main sequence; each scenario judges the block before the next one starts.
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    sc_regs();
    sc_loop();
    sc_history();
    sc_switch();
    sc_user();
    sc_clear();
    end_of_test();
  end
endmodule : hhlc_top_tb
